// ---- include/adc_dac_pkg.sv ----
// Shared constants and types of the converter sequencer
package adc_dac_pkg;
  // Register addresses on the special-function register port
  localparam logic [7:0] ADDR_ADC_RESULT  = 8'hc2;
  localparam logic [7:0] ADDR_ADC_CONTROL = 8'hc3;
  localparam logic [7:0] ADDR_DAC_VALUE   = 8'hc4;
  // Control register field positions
  localparam int unsigned CTRL_REQ_BIT  = 0;
  localparam int unsigned CTRL_CHAN_BIT = 1;
  localparam int unsigned CTRL_AUTO_BIT = 2;
  // Reset values and unmapped read value
  localparam logic [7:0] ADC_RESULT_RESET  = 8'h00;
  localparam logic [7:0] ADC_CONTROL_RESET = 8'h00;
  localparam logic [7:0] DAC_VALUE_RESET   = 8'h80;
  localparam logic [7:0] UNMAPPED_READ     = 8'h00;
  // Converter shape
  localparam int unsigned CODE_WIDTH = 8;
  localparam int unsigned ADC_STEPS  = 8;
  localparam logic [7:0]  TRIAL_START = 8'h80;
  // Timing
  localparam int unsigned CLK_PERIOD_NS  = 100;
  localparam int unsigned SLOT_TIME_NS   = 2000;
  localparam int unsigned SLOT_CYCLES    = SLOT_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned AUTO_PERIOD_MS = 30;
  localparam int unsigned AUTO_PERIOD_CYCLES =
    AUTO_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned DAC_SETTLE_US  = 25;
  localparam int unsigned DAC_SETTLE_CYCLES =
    DAC_SETTLE_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned RESULT_LIMIT_MS = 50;
  // State machines
  typedef enum logic [1:0] {SLOT_IDLE, SLOT_ADC, SLOT_DAC} slot_state_type;
  typedef enum logic {SEQ_IDLE, SEQ_TRIAL} seq_state_type;
endpackage

// ---- include/vgen_if.sv ----
// Slot requests between the sequencer and the generator slot control
`timescale 1ns/100ps
`default_nettype none
interface vgen_if;
  logic       adc_req;
  logic [7:0] adc_code;
  logic       dac_req;
  logic [7:0] dac_code;
  logic       adc_done;
  logic       adc_above;
  logic       dac_done;
  modport seq  (output adc_req, adc_code, dac_req, dac_code,
                input  adc_done, adc_above, dac_done);
  modport slot (input  adc_req, adc_code, dac_req, dac_code,
                output adc_done, adc_above, dac_done);
endinterface
`default_nettype wire

// ---- rtl/vgen_slot_ctrl.sv ----
// Time-slot owner of the shared voltage generator
`timescale 1ns/100ps
`default_nettype none
module vgen_slot_ctrl
  import adc_dac_pkg::*;
#(
  parameter int unsigned SLOT_LEN = SLOT_CYCLES
) (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       system_on_in,
  input  wire logic       comparator_in,
  vgen_if.slot            bus,
  output logic [7:0]      vgen_code_out,
  output logic            vgen_to_dac_out,
  output logic            dac_latch_out
);
  localparam int unsigned CW = $clog2(SLOT_LEN + 1);
  localparam logic [CW-1:0] SLOT_LAST = CW'(SLOT_LEN - 1);

  slot_state_type state_reg, state_next;
  logic [CW-1:0]  cnt_reg, cnt_next;
  logic [7:0]     code_reg, code_next;
  logic           adone_reg, adone_next;
  logic           above_reg, above_next;
  logic           ddone_reg, ddone_next;

  // One owner per slot; a request waits until the slot ends
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    code_next  = code_reg;
    adone_next = 1'b0;
    above_next = above_reg;
    ddone_next = 1'b0;
    case (state_reg)
      SLOT_IDLE: begin
        // Done pulse guards against the stale request just answered
        if (system_on_in && bus.dac_req && !ddone_reg) begin
          state_next = SLOT_DAC;
          code_next  = bus.dac_code;
          cnt_next   = SLOT_LAST;
        end else if (system_on_in && bus.adc_req && !adone_reg) begin
          state_next = SLOT_ADC;
          code_next  = bus.adc_code;
          cnt_next   = SLOT_LAST;
        end
      end
      SLOT_ADC: begin
        if (cnt_reg == '0) begin
          state_next = SLOT_IDLE;
          adone_next = 1'b1;
          above_next = comparator_in; // Sampled after settling
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      SLOT_DAC: begin
        if (cnt_reg == '0) begin
          state_next = SLOT_IDLE;
          ddone_next = 1'b1;
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      default: state_next = SLOT_IDLE;
    endcase
  end

  // Slot registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_reg <= SLOT_IDLE;
      cnt_reg   <= '0;
      code_reg  <= '0;
      adone_reg <= 1'b0;
      above_reg <= 1'b0;
      ddone_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      code_reg  <= code_next;
      adone_reg <= adone_next;
      above_reg <= above_next;
      ddone_reg <= ddone_next;
    end
  end

  // Outputs straight from registers
  assign vgen_code_out   = code_reg;
  assign vgen_to_dac_out = (state_reg == SLOT_DAC);
  assign dac_latch_out   = ddone_reg;
  assign bus.adc_done    = adone_reg;
  assign bus.adc_above   = above_reg;
  assign bus.dac_done    = ddone_reg;
endmodule // vgen_slot_ctrl
`default_nettype wire

// ---- rtl/converter_sequencer.sv ----
// Converter sequencer: registers, conversion control, DAC updates
// Notes on behaviour
// - Logic runs whenever system-on mode holds
// - One shared generator serves ADC and DAC
// - Successive approximation, eight comparisons per conversion
// - Final trial copied to result at once
// - Request bit starts; hardware clears when done
// - Result ready well under fifty milliseconds
// - Auto bit converts every thirty milliseconds
// - Channel bit picks first or second input
// - Control bits seven to three reserved
// - Read-only eight-bit result, resets to zero
// - Single eight-bit DAC, one value register
// - DAC write updates output within 25 us; a write during a DAC slot never reaches it
// - DAC value resets to 80 hex
`timescale 1ns/100ps
`default_nettype none
module converter_sequencer
  import adc_dac_pkg::*;
#(
  parameter int unsigned AUTO_PERIOD = AUTO_PERIOD_CYCLES,
  parameter int unsigned SLOT_LEN    = SLOT_CYCLES
) (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       system_on_in,
  input  wire logic [7:0] sfr_addr_in,
  input  wire logic [7:0] sfr_wdata_in,
  input  wire logic       sfr_wr_in,
  input  wire logic       sfr_rd_in,
  output logic [7:0]      sfr_rdata_out,
  input  wire logic       comparator_in,
  output logic            channel_select_out,
  output logic [7:0]      vgen_code_out,
  output logic            vgen_to_dac_out,
  output logic            dac_latch_out,
  output logic            adc_busy_out
);
  localparam int unsigned AW = $clog2(AUTO_PERIOD + 1);
  localparam logic [AW-1:0] AUTO_LAST = AW'(AUTO_PERIOD - 1);
  localparam logic [2:0] STEP_LAST = 3'(ADC_STEPS - 1);

  vgen_if vbus ();

  // Register file and sequencer state
  logic           req_reg, req_next;
  logic           chan_reg, chan_next;
  logic           auto_reg, auto_next;
  logic [7:0]     result_reg, result_next;
  logic [7:0]     dac_reg, dac_next;
  logic           dac_pend_reg, dac_pend_next;
  logic [7:0]     rdata_reg, rdata_next;
  seq_state_type  state_reg, state_next;
  logic [7:0]     trial_reg, trial_next;
  logic [2:0]     step_reg, step_next;
  logic [AW-1:0]  auto_cnt_reg, auto_cnt_next;
  logic           auto_pend_reg, auto_pend_next;

  logic wr_ctrl;
  logic wr_dac;
  logic auto_tick;
  logic start;
  logic finish;
  logic [7:0] keep_bit;

  // Address decode of the write strobe
  always_comb begin
    wr_ctrl = 1'b0;
    wr_dac  = 1'b0;
    if (sfr_wr_in && sfr_addr_in == ADDR_ADC_CONTROL) begin
      wr_ctrl = 1'b1;
    end else if (sfr_wr_in && sfr_addr_in == ADDR_DAC_VALUE) begin
      wr_dac = 1'b1;
    end
  end

  // Conversion start and finish conditions
  assign auto_tick = auto_reg && (auto_cnt_reg == '0);
  assign start  = (state_reg == SEQ_IDLE) && system_on_in
                  && (req_reg || auto_pend_reg);
  assign finish = (state_reg == SEQ_TRIAL) && vbus.adc_done
                  && (step_reg == '0);
  // Decision bit: kept when input sits above the trial level
  assign keep_bit = 8'h01 << step_reg;

  // Control, result and DAC value registers
  always_comb begin
    req_next      = req_reg;
    chan_next     = chan_reg;
    auto_next     = auto_reg;
    result_next   = result_reg;
    dac_next      = dac_reg;
    dac_pend_next = dac_pend_reg;
    // Hardware clear first so a same-cycle software set wins
    if (finish) begin
      req_next    = 1'b0;
      result_next = vbus.adc_above ? trial_reg
                                   : (trial_reg & ~keep_bit);
    end
    if (wr_ctrl) begin
      // Bits 7..3 are dropped on write; writing 0 cannot abort
      req_next  = req_next | sfr_wdata_in[CTRL_REQ_BIT];
      chan_next = sfr_wdata_in[CTRL_CHAN_BIT];
      auto_next = sfr_wdata_in[CTRL_AUTO_BIT];
    end
    if (vbus.dac_done) begin
      dac_pend_next = 1'b0;
    end
    if (wr_dac) begin
      dac_next      = sfr_wdata_in;
      dac_pend_next = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      req_reg      <= ADC_CONTROL_RESET[CTRL_REQ_BIT];
      chan_reg     <= ADC_CONTROL_RESET[CTRL_CHAN_BIT];
      auto_reg     <= ADC_CONTROL_RESET[CTRL_AUTO_BIT];
      result_reg   <= ADC_RESULT_RESET;
      dac_reg      <= DAC_VALUE_RESET;
      dac_pend_reg <= 1'b1; // Drive mid-range out right after reset
    end else begin
      req_reg      <= req_next;
      chan_reg     <= chan_next;
      auto_reg     <= auto_next;
      result_reg   <= result_next;
      dac_reg      <= dac_next;
      dac_pend_reg <= dac_pend_next;
    end
  end

  // Successive approximation walk, one comparison per generator slot
  always_comb begin
    state_next = state_reg;
    trial_next = trial_reg;
    step_next  = step_reg;
    case (state_reg)
      SEQ_IDLE: begin
        if (start) begin
          state_next = SEQ_TRIAL;
          trial_next = TRIAL_START;
          step_next  = STEP_LAST;
        end
      end
      SEQ_TRIAL: begin
        if (vbus.adc_done) begin
          if (!vbus.adc_above) begin
            trial_next = trial_reg & ~keep_bit;
          end
          if (step_reg == '0) begin
            state_next = SEQ_IDLE;
          end else begin
            step_next  = step_reg - 1'b1;
            trial_next[step_reg - 1'b1] = 1'b1;
          end
        end
      end
      default: state_next = SEQ_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_reg <= SEQ_IDLE;
      trial_reg <= '0;
      step_reg  <= '0;
    end else begin
      state_reg <= state_next;
      trial_reg <= trial_next;
      step_reg  <= step_next;
    end
  end

  // Auto-conversion period; a tick during a conversion is kept pending
  always_comb begin
    auto_cnt_next  = auto_cnt_reg;
    auto_pend_next = auto_pend_reg;
    if (!auto_reg) begin
      auto_cnt_next  = AUTO_LAST;
      auto_pend_next = 1'b0;
    end else begin
      auto_cnt_next = (auto_cnt_reg == '0) ? AUTO_LAST
                                           : auto_cnt_reg - 1'b1;
      if (start) begin
        auto_pend_next = 1'b0;
      end
      if (auto_tick) begin
        auto_pend_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      auto_cnt_reg  <= AUTO_LAST;
      auto_pend_reg <= 1'b0;
    end else begin
      auto_cnt_reg  <= auto_cnt_next;
      auto_pend_reg <= auto_pend_next;
    end
  end

  // Registered read data; unmapped and reserved bits read zero
  always_comb begin
    rdata_next = rdata_reg;
    if (sfr_rd_in) begin
      if (sfr_addr_in == ADDR_ADC_RESULT) begin
        rdata_next = result_reg;
      end else if (sfr_addr_in == ADDR_ADC_CONTROL) begin
        rdata_next = 8'h00;
        rdata_next[CTRL_REQ_BIT]  = req_reg;
        rdata_next[CTRL_CHAN_BIT] = chan_reg;
        rdata_next[CTRL_AUTO_BIT] = auto_reg;
      end else if (sfr_addr_in == ADDR_DAC_VALUE) begin
        rdata_next = dac_reg;
      end else begin
        rdata_next = UNMAPPED_READ;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Requests into the shared generator
  assign vbus.adc_req  = (state_reg == SEQ_TRIAL);
  assign vbus.adc_code = trial_reg;
  assign vbus.dac_req  = dac_pend_reg;
  assign vbus.dac_code = dac_reg;

  vgen_slot_ctrl #(
    .SLOT_LEN (SLOT_LEN)
  ) u_slot (
    .clk_in          (clk_in),
    .rst_in          (rst_in),
    .system_on_in    (system_on_in),
    .comparator_in   (comparator_in),
    .bus             (vbus.slot),
    .vgen_code_out   (vgen_code_out),
    .vgen_to_dac_out (vgen_to_dac_out),
    .dac_latch_out   (dac_latch_out)
  );

  // Channel follows the bit; software keeps it still while busy
  assign channel_select_out = chan_reg;
  assign adc_busy_out       = (state_reg == SEQ_TRIAL);
  assign sfr_rdata_out      = rdata_reg;
endmodule // converter_sequencer
`default_nettype wire

// ---- bench/converter_sequencer_chk.sv ----
// Port checker for the converter sequencer
`timescale 1ns/100ps
`default_nettype none
module converter_sequencer_chk
  import adc_dac_pkg::*;
#(
  parameter int unsigned AUTO_PERIOD = AUTO_PERIOD_CYCLES,
  parameter int unsigned SLOT_LEN    = SLOT_CYCLES
) (
  input wire logic       clk_in,
  input wire logic       rst_in,
  input wire logic       system_on_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic       sfr_wr_in,
  input wire logic       sfr_rd_in,
  input wire logic [7:0] sfr_rdata_out,
  input wire logic       comparator_in,
  input wire logic       channel_select_out,
  input wire logic [7:0] vgen_code_out,
  input wire logic       vgen_to_dac_out,
  input wire logic       dac_latch_out,
  input wire logic       adc_busy_out
);
  logic [7:0] dac_cnt_reg;
  logic [7:0] dac_cnt_next;
  // Counts DAC slot cycles; a repetition cannot take a parameter
  always_comb begin
    dac_cnt_next = vgen_to_dac_out ? dac_cnt_reg + 8'h01 : 8'h00;
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      dac_cnt_reg <= 8'h00;
    end else begin
      dac_cnt_reg <= dac_cnt_next;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // Port relations over time
  busy_bound_a: assert property (
    $rose(adc_busy_out) |-> ##[1:300] !adc_busy_out)
    else $error("conversion overran its bound");
  sys_off_idle_a: assert property (
    !system_on_in && !adc_busy_out |=> !adc_busy_out)
    else $error("conversion started outside system-on");
  latch_at_end_a: assert property (
    $fell(vgen_to_dac_out) |-> dac_latch_out)
    else $error("no latch at end of DAC slot");
  latch_pulse_a: assert property (dac_latch_out |=> !dac_latch_out)
    else $error("latch pulse longer than one cycle");
  dac_write_latch_a: assert property (
    sfr_wr_in && sfr_addr_in == ADDR_DAC_VALUE |-> ##[1:250] dac_latch_out)
    else $error("DAC write not latched in time");
  dac_code_hold_a: assert property (
    vgen_to_dac_out && $past(vgen_to_dac_out) |-> $stable(vgen_code_out))
    else $error("generator code moved in DAC slot");
  ctrl_reserved_a: assert property (
    sfr_rd_in && sfr_addr_in == ADDR_ADC_CONTROL
    |=> sfr_rdata_out[7:3] == 5'h00)
    else $error("reserved control bits read nonzero");
  dac_slot_len_a: assert property (
    $fell(vgen_to_dac_out) |-> {24'h0, dac_cnt_reg} == SLOT_LEN)
    else $error("DAC slot length wrong");
  reset_idle_a: assert property (disable iff (1'b0)
    rst_in |=> !adc_busy_out && sfr_rdata_out == 8'h00)
    else $error("reset state wrong");
  cover property ($fell(adc_busy_out));
  cover property (adc_busy_out && vgen_to_dac_out);
  cover property (dac_latch_out);
endmodule // converter_sequencer_chk
bind converter_sequencer converter_sequencer_chk #(
  .AUTO_PERIOD(AUTO_PERIOD), .SLOT_LEN(SLOT_LEN)) chk_i (
  .clk_in, .rst_in, .system_on_in, .sfr_addr_in, .sfr_wdata_in,
  .sfr_wr_in, .sfr_rd_in, .sfr_rdata_out, .comparator_in,
  .channel_select_out, .vgen_code_out, .vgen_to_dac_out,
  .dac_latch_out, .adc_busy_out);
`default_nettype wire

// ---- bench/analog_side_model.sv ----
// Behavioural generator, comparator and DAC output hold
`timescale 1ns/100ps
`default_nettype none
module analog_side_model (
  input  wire logic       clk_in,
  input  wire logic       channel_select_in,
  input  wire logic [7:0] vgen_code_in,
  input  wire logic       vgen_to_dac_in,
  input  wire logic       dac_latch_in,
  input  wire logic [7:0] level_first_in,
  input  wire logic [7:0] level_second_in,
  output logic            comparator_out,
  output logic [7:0]      dac_level_out
);
  logic junk_reg;
  // Decision is garbage while the DAC owns the generator
  always_comb begin
    if (vgen_to_dac_in) begin
      comparator_out = junk_reg;
    end else if (channel_select_in) begin
      comparator_out = level_second_in >= vgen_code_in;
    end else begin
      comparator_out = level_first_in >= vgen_code_in;
    end
  end
  // Output hold takes the level on the latch pulse
  // Plain always, since the initial block also writes junk_reg
  always @(posedge clk_in) begin
    junk_reg <= ~junk_reg;
    if (dac_latch_in) begin
      dac_level_out <= vgen_code_in;
    end
  end
  initial junk_reg = 1'b0;
endmodule // analog_side_model
`default_nettype wire

// ---- bench/test_converter_sequencer.sv ----
// Self-checking bench for the converter sequencer
`timescale 1ns/100ps
`default_nettype none
module test_converter_sequencer
  import adc_dac_pkg::*;
;
  localparam int unsigned AUTO_P = 200;
  localparam int unsigned SLOT_P = 4;
  localparam int CONV_MAX = 8 * (SLOT_P + 2) + 8;
  logic       clk_in = 1'b0;
  logic       rst_in = 1'b1;
  logic       system_on_in = 1'b1;
  logic [7:0] sfr_addr_in = 8'h00;
  logic [7:0] sfr_wdata_in = 8'h00;
  logic       sfr_wr_in = 1'b0;
  logic       sfr_rd_in = 1'b0;
  logic [7:0] level_first = 8'h00;
  logic [7:0] level_second = 8'h00;
  logic [7:0] sfr_rdata_out, vgen_code_out, dac_level;
  logic       comparator_in, channel_select_out, vgen_to_dac_out;
  logic       dac_latch_out, adc_busy_out;
  int         n_fail = 0;
  int         n_checks = 0;
  // Clock and the two sides
  always #50 clk_in = ~clk_in;
  converter_sequencer #(.AUTO_PERIOD(AUTO_P), .SLOT_LEN(SLOT_P)) dut (
    .clk_in, .rst_in, .system_on_in, .sfr_addr_in, .sfr_wdata_in,
    .sfr_wr_in, .sfr_rd_in, .sfr_rdata_out, .comparator_in,
    .channel_select_out, .vgen_code_out, .vgen_to_dac_out,
    .dac_latch_out, .adc_busy_out);
  analog_side_model model (.clk_in, .channel_select_in(channel_select_out),
    .vgen_code_in(vgen_code_out), .vgen_to_dac_in(vgen_to_dac_out),
    .dac_latch_in(dac_latch_out), .level_first_in(level_first),
    .level_second_in(level_second), .comparator_out(comparator_in),
    .dac_level_out(dac_level));
  task automatic summarize;
    if (n_fail == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    sfr_addr_in <= a;
    sfr_wdata_in <= d;
    sfr_wr_in <= 1'b1;
    @(posedge clk_in);
    sfr_wr_in <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    sfr_addr_in <= a;
    sfr_rd_in <= 1'b1;
    @(posedge clk_in);
    sfr_rd_in <= 1'b0;
    @(posedge clk_in);
    #1 chk(sfr_rdata_out, exp);
  endtask
  // Bounded wait: 0 busy low, 1 busy high, 2 latch pulse
  task automatic wait_for(input int sel, input int bound, output int n);
    n = 0;
    do begin
      @(posedge clk_in);
      #1 n++;
    end while (!((sel == 0 && adc_busy_out === 1'b0) ||
                 (sel == 1 && adc_busy_out === 1'b1) ||
                 (sel == 2 && dac_latch_out === 1'b1)) && n < bound);
    if (n >= bound) begin
      n_fail++;
      summarize();
    end
  endtask
  task automatic t_reset;
    int n;
    wait_for(2, 60, n);
    // Output hold takes the level one edge after the pulse
    @(posedge clk_in);
    #1 chk(dac_level, DAC_VALUE_RESET);
    rchk(ADDR_ADC_RESULT, 8'h00);
    rchk(ADDR_ADC_CONTROL, 8'h00);
    rchk(ADDR_DAC_VALUE, 8'h80);
    rchk(8'hc5, UNMAPPED_READ);
  endtask
  // Channel changes only while idle
  task automatic t_convert(input logic ch, input logic [7:0] lvl);
    int n;
    @(posedge clk_in);
    if (ch) level_second <= lvl;
    else level_first <= lvl;
    wr(ADDR_ADC_CONTROL, {6'h00, ch, 1'b1});
    wait_for(1, 10, n);
    wait_for(0, 300, n);
    rchk(ADDR_ADC_RESULT, lvl);
    rchk(ADDR_ADC_CONTROL, {6'h00, ch, 1'b0});
  endtask
  task automatic t_busy_req;
    int n;
    wr(ADDR_ADC_CONTROL, 8'h01);
    wait_for(1, 10, n);
    repeat (10) @(posedge clk_in);
    wr(ADDR_ADC_CONTROL, 8'h01);
    wait_for(0, 300, n);
    chk({7'h0, n + 12 <= CONV_MAX}, 8'h01);
    repeat (20) @(posedge clk_in);
    #1 chk({7'h0, adc_busy_out}, 8'h00);
    wr(ADDR_ADC_CONTROL, 8'hf8);
    rchk(ADDR_ADC_CONTROL, 8'h00);
    wr(ADDR_ADC_RESULT, 8'h33);
    rchk(ADDR_ADC_RESULT, level_first);
  endtask
  task automatic t_dac(input logic [7:0] v, input logic conv);
    int n;
    if (conv) wr(ADDR_ADC_CONTROL, 8'h01);
    wr(ADDR_DAC_VALUE, v);
    wait_for(2, 250, n);
    @(posedge clk_in);
    #1 chk(dac_level, v);
    rchk(ADDR_DAC_VALUE, v);
    wait_for(0, 300, n);
    rchk(ADDR_ADC_RESULT, level_first);
  endtask
  task automatic t_auto;
    int  n;
    time t0;
    wr(ADDR_ADC_CONTROL, 8'h04);
    wait_for(1, AUTO_P + 20, n);
    t0 = $time;
    wait_for(0, 300, n);
    rchk(ADDR_ADC_CONTROL, 8'h04);
    wait_for(1, AUTO_P + 20, n);
    chk(8'(($time - t0) / 100), 8'(AUTO_P));
    wr(ADDR_ADC_CONTROL, 8'h00);
    wait_for(0, 300, n);
    repeat (AUTO_P + 20) @(posedge clk_in);
    #1 chk({7'h0, adc_busy_out}, 8'h00);
  endtask
  task automatic t_sysoff;
    int n;
    @(posedge clk_in);
    system_on_in <= 1'b0;
    wr(ADDR_ADC_CONTROL, 8'h01);
    repeat (30) @(posedge clk_in);
    #1 chk({7'h0, adc_busy_out}, 8'h00);
    @(posedge clk_in);
    system_on_in <= 1'b1;
    wait_for(1, 10, n);
    wait_for(0, 300, n);
    rchk(ADDR_ADC_RESULT, level_first);
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    t_reset();
    t_convert(1'b0, 8'h5a);
    t_convert(1'b1, 8'ha5);
    t_convert(1'b0, 8'hff);
    t_convert(1'b1, 8'h00);
    t_busy_req();
    t_dac(8'h3c, 1'b0);
    t_dac(8'hff, 1'b0);
    t_dac(8'hc3, 1'b1);
    t_auto();
    t_sysoff();
    summarize();
  end
endmodule // test_converter_sequencer
`default_nettype wire
